// ### common/tcrb_pkg.sv
// Overview of operation
// - Overflow flag is set whenever the 16-bit count rolls over, except in baud-rate generator mode.
// - Counting down, overflow flag is also set when count equals capture/reload value.
// - Overflow flag is set only when both baud select bits are zero.
// - Hardware never clears the overflow flag; software may set or clear it.
// - External flag sets on trigger falling edge or overflow, per mode bits.
// - Timer interrupt is requested, when enabled, while the overflow flag or the external flag is set.
// - Receive baud select picks timer 1 or this timer overflow in modes 1, 3.
// - Transmit baud select picks timer 1 or this timer overflow in modes 1, 3.
// - Either baud select bit forces baud-rate generator mode.
// - Trigger pin falling edges ignored unless enabled and not generating baud clocks.
// - Run control low stops counting; the count holds except for trigger events and register writes.
// - In baud-rate generator mode the timer advances once every two clocks.
// - Outside baud mode, timer select zero counts prescaled ticks; one counts count-pin falling edges.
// - Baud mode ignores capture/reload select and reloads after every overflow.
// - With down count disabled, reload mode reloads on overflow and on enabled trigger falling edge.
// - Capture mode copies the count on each enabled trigger falling edge.
// - Capture with auto clear set clears the count after the copy.
// - In auto-reload mode, down enable and trigger level pick count direction.
// - Low capture register takes low count byte; supplies low reload byte.
// - High capture register takes high count byte; supplies high reload byte.
package tcrb_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CONTROL = 10'h0C8;
   localparam logic [9:0] IDX_MODE = 10'h0C9;
   localparam logic [9:0] IDX_RELOAD_LOW = 10'h0CA;
   localparam logic [9:0] IDX_RELOAD_HIGH = 10'h0CB;
   localparam logic [9:0] IDX_COUNT_LOW = 10'h0CC;
   localparam logic [9:0] IDX_COUNT_HIGH = 10'h0CD;
   localparam logic [9:0] IDX_CLOCK_CONTROL = 10'h0CE;
   // control register fields
   localparam int CTL_OVERFLOW_FLAG = 7;
   localparam int CTL_EXTERNAL_FLAG = 6;
   localparam int CTL_RX_BAUD_SELECT = 5;
   localparam int CTL_TX_BAUD_SELECT = 4;
   localparam int CTL_TRIGGER_ENABLE = 3;
   localparam int CTL_RUN_CONTROL = 2;
   localparam int CTL_COUNTER_SELECT = 1;
   localparam int CTL_CAPTURE_SELECT = 0;
   // mode register fields
   localparam int MOD_CAPTURE_AUTO_CLEAR = 3;
   localparam int MOD_DOWN_COUNT_ENABLE = 0;
   // clock control field
   localparam int CKC_TICK_SPEED_SELECT = 5;
   // reset values and count maximum
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   // clocks per tick
   localparam logic [3:0] DIV_BAUD = 4'h2;
   localparam logic [3:0] DIV_SLOW = 4'hC;
   localparam logic [3:0] DIV_FAST = 4'h4;
endpackage

// ### src/tcrb_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tcrb_edge (
   // clock
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // pin
   input wire logic pin,
   // results
   output logic level,
   output logic fall
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   // two-stage synchroniser, then one more sample for the compare
   always_ff @(posedge clock) begin
      if (!resetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else if (ce) begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   assign level = sync2_reg;
   assign fall = ce && prev_reg && !sync2_reg;
endmodule
`default_nettype wire

// ### src/tcrb_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tcrb_prescale (
   // clock
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // control
   input wire logic enable,
   input wire logic [3:0] divide,
   // result
   output logic tick
);
   logic [3:0] cnt_reg;
   logic last;

   assign last = (cnt_reg >= divide - 4'h1);
   assign tick = ce && enable && last;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cnt_reg <= 4'h0;
      end else if (ce) begin
         if (!enable || last) begin
            cnt_reg <= 4'h0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### src/tcrb_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcrb_timer (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic external_trigger_pin,
   input wire logic count_input_pin,
   // serial port side
   input wire logic [1:0] serial_mode,
   input wire logic timer1_overflow,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   output logic overflow_pulse,
   // interrupt side
   input wire logic irq_enable,
   output logic timer_irq
);
   logic [7:0] control_reg;
   logic [7:0] control_next;
   logic [7:0] mode_reg;
   logic [7:0] clock_control_reg;
   logic [15:0] reload_reg;
   logic [15:0] reload_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [31:0] prdata_reg;

   // bus decode
   logic [9:0] index;
   logic aligned;
   logic hit;
   logic acc_write;
   logic setup_read;
   logic wr_control;
   logic wr_mode;
   logic wr_clock_control;
   logic wr_reload_low;
   logic wr_reload_high;
   logic wr_count_low;
   logic wr_count_high;
   logic [7:0] rd_byte;

   assign index = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign hit = aligned && (index >= tcrb_pkg::IDX_CONTROL) && (index <= tcrb_pkg::IDX_CLOCK_CONTROL);
   assign acc_write = ce && psel && penable && pwrite && hit;
   assign setup_read = ce && psel && !penable && !pwrite;
   assign wr_control = acc_write && (index == tcrb_pkg::IDX_CONTROL);
   assign wr_mode = acc_write && (index == tcrb_pkg::IDX_MODE);
   assign wr_clock_control = acc_write && (index == tcrb_pkg::IDX_CLOCK_CONTROL);
   assign wr_reload_low = acc_write && (index == tcrb_pkg::IDX_RELOAD_LOW);
   assign wr_reload_high = acc_write && (index == tcrb_pkg::IDX_RELOAD_HIGH);
   assign wr_count_low = acc_write && (index == tcrb_pkg::IDX_COUNT_LOW);
   assign wr_count_high = acc_write && (index == tcrb_pkg::IDX_COUNT_HIGH);

   assign rd_byte = !hit ? 8'h00 :
      (index == tcrb_pkg::IDX_CONTROL) ? control_reg :
      (index == tcrb_pkg::IDX_MODE) ? mode_reg :
      (index == tcrb_pkg::IDX_RELOAD_LOW) ? reload_reg[7:0] :
      (index == tcrb_pkg::IDX_RELOAD_HIGH) ? reload_reg[15:8] :
      (index == tcrb_pkg::IDX_COUNT_LOW) ? count_reg[7:0] :
      (index == tcrb_pkg::IDX_COUNT_HIGH) ? count_reg[15:8] :
      clock_control_reg;

   assign pready = ce;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_reg;

   // mode decode
   logic baud_mode;
   logic run;
   logic counter_mode;
   logic reload_mode;
   logic capture_mode;
   logic updown_mode;
   logic trig_level;
   logic trig_fall;
   logic cnt_fall;
   logic pre_tick;
   logic pre_enable;
   logic [3:0] pre_divide;
   logic step;
   logic count_down;
   logic at_max;
   logic at_reload;
   logic overflow_up;
   logic overflow_down;
   logic overflow;
   logic trig_ok;
   logic capture_event;
   logic edge_reload;
   logic set_overflow;
   logic set_external;

   assign baud_mode = control_reg[tcrb_pkg::CTL_RX_BAUD_SELECT] |
      control_reg[tcrb_pkg::CTL_TX_BAUD_SELECT];
   assign run = control_reg[tcrb_pkg::CTL_RUN_CONTROL];
   assign counter_mode = control_reg[tcrb_pkg::CTL_COUNTER_SELECT] && !baud_mode;
   assign reload_mode = baud_mode || !control_reg[tcrb_pkg::CTL_CAPTURE_SELECT];
   assign capture_mode = !reload_mode;
   assign updown_mode = reload_mode && !baud_mode &&
      mode_reg[tcrb_pkg::MOD_DOWN_COUNT_ENABLE];

   tcrb_edge u_trig (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .pin(external_trigger_pin),
      .level(trig_level),
      .fall(trig_fall)
   );

   tcrb_edge u_count (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .pin(count_input_pin),
      .level(),
      .fall(cnt_fall)
   );

   // tick source
   assign pre_enable = run && !counter_mode;
   assign pre_divide = baud_mode ? tcrb_pkg::DIV_BAUD :
      clock_control_reg[tcrb_pkg::CKC_TICK_SPEED_SELECT] ? tcrb_pkg::DIV_FAST :
      tcrb_pkg::DIV_SLOW;

   tcrb_prescale u_pre (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .enable(pre_enable),
      .divide(pre_divide),
      .tick(pre_tick)
   );

   assign step = run && (counter_mode ? cnt_fall : pre_tick);

   // direction and overflow
   assign count_down = updown_mode && !trig_level;
   assign at_max = (count_reg == tcrb_pkg::COUNT_MAX);
   assign at_reload = (count_reg == reload_reg);
   assign overflow_up = step && !count_down && at_max;
   assign overflow_down = step && count_down && at_reload;
   assign overflow = overflow_up || overflow_down;

   // trigger pin events
   assign trig_ok = trig_fall && control_reg[tcrb_pkg::CTL_TRIGGER_ENABLE] && !baud_mode;
   assign capture_event = trig_ok && capture_mode;
   assign edge_reload = trig_ok && reload_mode && !updown_mode;

   // flag sources
   assign set_overflow = overflow && !baud_mode;
   assign set_external = trig_ok || (overflow && updown_mode);

   always_comb begin
      control_next = wr_control ? pwdata[7:0] : control_reg;
      if (set_overflow) begin
         control_next[tcrb_pkg::CTL_OVERFLOW_FLAG] = 1'b1;
      end
      if (set_external) begin
         control_next[tcrb_pkg::CTL_EXTERNAL_FLAG] = 1'b1;
      end
   end

   always_comb begin
      count_next = count_reg;
      if (step) begin
         if (overflow_down) begin
            count_next = tcrb_pkg::COUNT_MAX;
         end else if (overflow_up && reload_mode) begin
            count_next = reload_reg;
         end else if (count_down) begin
            count_next = count_reg - 16'h0001;
         end else begin
            count_next = count_reg + 16'h0001;
         end
      end
      if (edge_reload) begin
         count_next = reload_reg;
      end
      if (capture_event && mode_reg[tcrb_pkg::MOD_CAPTURE_AUTO_CLEAR]) begin
         count_next = tcrb_pkg::COUNT_RESET;
      end
      if (wr_count_low) begin
         count_next[7:0] = pwdata[7:0];
      end
      if (wr_count_high) begin
         count_next[15:8] = pwdata[7:0];
      end
   end

   always_comb begin
      reload_next = capture_event ? count_reg : reload_reg;
      if (wr_reload_low) begin
         reload_next[7:0] = pwdata[7:0];
      end
      if (wr_reload_high) begin
         reload_next[15:8] = pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         control_reg <= tcrb_pkg::CONTROL_RESET;
         mode_reg <= tcrb_pkg::MODE_RESET;
         clock_control_reg <= tcrb_pkg::CLOCK_CONTROL_RESET;
         reload_reg <= tcrb_pkg::RELOAD_RESET;
         count_reg <= tcrb_pkg::COUNT_RESET;
         prdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         control_reg <= control_next;
         reload_reg <= reload_next;
         count_reg <= count_next;
         if (wr_mode) begin
            mode_reg <= pwdata[7:0];
         end
         if (wr_clock_control) begin
            clock_control_reg <= pwdata[7:0];
         end
         if (setup_read) begin
            prdata_reg <= {24'h000000, rd_byte};
         end
      end
   end

   // serial time base and interrupt
   assign overflow_pulse = overflow;
   assign rx_baud_tick = serial_mode[0] &&
      (control_reg[tcrb_pkg::CTL_RX_BAUD_SELECT] ? overflow : timer1_overflow);
   assign tx_baud_tick = serial_mode[0] &&
      (control_reg[tcrb_pkg::CTL_TX_BAUD_SELECT] ? overflow : timer1_overflow);
   assign timer_irq = irq_enable && (control_reg[tcrb_pkg::CTL_EXTERNAL_FLAG] ||
      control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG]);

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   property p_up_overflow;
      ce && overflow_up && !baud_mode |=> control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG];
   endproperty
   a_up_overflow: assert property (p_up_overflow) else $error("overflow flag not set on rollover");

   property p_down_match;
      ce && step && count_down && at_reload |=>
         control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG] && count_reg == tcrb_pkg::COUNT_MAX;
   endproperty
   a_down_match: assert property (p_down_match) else $error("down match missed");

   property p_baud_no_flag;
      ce && baud_mode && !control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG] && !wr_control
         |=> !control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG];
   endproperty
   a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud mode");

   property p_flag_sticky;
      control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG] && !wr_control |=> control_reg[tcrb_pkg::CTL_OVERFLOW_FLAG];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost");

   property p_edge_flag;
      trig_ok |=> control_reg[tcrb_pkg::CTL_EXTERNAL_FLAG];
   endproperty
   a_edge_flag: assert property (p_edge_flag) else $error("external flag not set");

   property p_irq;
      irq_enable && control_reg[tcrb_pkg::CTL_EXTERNAL_FLAG] |-> timer_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_rx_select;
      serial_mode[0] && !control_reg[tcrb_pkg::CTL_RX_BAUD_SELECT] |-> rx_baud_tick == timer1_overflow;
   endproperty
   a_rx_select: assert property (p_rx_select) else $error("receive time base wrong");

   property p_hold;
      ce && !run && !wr_count_low && !wr_count_high && !edge_reload && !capture_event |=> $stable(count_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while stopped");

   sequence s_baud_tick;
      ce && baud_mode && run && pre_tick;
   endsequence
   sequence s_baud_hold;
      ce && baud_mode && run;
   endsequence
   property p_baud_rate;
      s_baud_tick ##1 s_baud_hold |-> !pre_tick ##1 (!(ce && baud_mode && run) || pre_tick);
   endproperty
   a_baud_rate: assert property (p_baud_rate) else $error("baud tick not every two clocks");

   property p_capture;
      ce && capture_event && !wr_reload_low && !wr_reload_high |=> reload_reg == $past(count_reg);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_tx_select;
      serial_mode[0] && control_reg[tcrb_pkg::CTL_TX_BAUD_SELECT] && step && at_max |-> tx_baud_tick;
   endproperty
   a_tx_select: assert property (p_tx_select) else $error("transmit time base wrong");

   property p_trig_ignored;
      ce && trig_fall && (!control_reg[tcrb_pkg::CTL_TRIGGER_ENABLE] || baud_mode) && !run && !acc_write
         |=> $stable(count_reg) && $stable(reload_reg);
   endproperty
   a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

   property p_pin_count;
      ce && run && counter_mode && cnt_fall && !count_down && !at_max && !acc_write && !trig_ok
         |=> count_reg == $past(count_reg) + 16'h0001;
   endproperty
   a_pin_count: assert property (p_pin_count) else $error("count pin edge missed");

   property p_baud_reload;
      ce && baud_mode && step && at_max && !acc_write |=> count_reg == $past(reload_reg);
   endproperty
   a_baud_reload: assert property (p_baud_reload) else $error("baud overflow did not reload");

   property p_edge_reload;
      ce && edge_reload && !acc_write |=> count_reg == $past(reload_reg);
   endproperty
   a_edge_reload: assert property (p_edge_reload) else $error("trigger reload wrong");

   property p_auto_clear;
      ce && capture_event && mode_reg[tcrb_pkg::MOD_CAPTURE_AUTO_CLEAR] && !acc_write
         |=> count_reg == tcrb_pkg::COUNT_RESET;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("count not cleared after capture");

   property p_count_up;
      ce && step && updown_mode && trig_level && !at_max && !acc_write
         |=> count_reg == $past(count_reg) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("count did not go up");

   property p_count_down;
      ce && step && updown_mode && !trig_level && !at_reload && !acc_write
         |=> count_reg == $past(count_reg) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("count did not go down");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [9:0] CT = tcrb_pkg::IDX_CONTROL;
   localparam logic [9:0] MD = tcrb_pkg::IDX_MODE;
   localparam logic [9:0] RL = tcrb_pkg::IDX_RELOAD_LOW;
   localparam logic [9:0] CL = tcrb_pkg::IDX_COUNT_LOW;
   localparam logic [9:0] CK = tcrb_pkg::IDX_CLOCK_CONTROL;
   logic clock, resetn, psel, penable, pwrite, pready, pslverr, trig, cpin, t1, irq_en, irq, clr;
   logic rxt, txt, ovp;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] smode;
   logic [7:0] rxc, txc, ovc, t1c, q;
   logic [15:0] w, r, c;
   logic err;
   int n_mismatch = 0;
   int check_count = 0;
   tcrb_timer DUT (.clock(clock), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_trigger_pin(trig), .count_input_pin(cpin), .serial_mode(smode),
      .timer1_overflow(t1), .rx_baud_tick(rxt), .tx_baud_tick(txt), .overflow_pulse(ovp),
      .irq_enable(irq_en), .timer_irq(irq));
   tcrb_serial_model partner (.clock(clock), .clear(clr), .rx_baud_tick(rxt), .tx_baud_tick(txt),
      .overflow_pulse(ovp), .timer1_overflow(t1), .rx_count(rxc), .tx_count(txc),
      .ovf_count(ovc), .t1_count(t1c));
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task end_sim;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic wr, input logic [9:0] i, input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd16(input logic [9:0] i);
      apb(0, i, 8'h00);
      w[7:0] = q;
      apb(0, i + 10'h001, 8'h00);
      w[15:8] = q;
   endtask
   task wr16(input logic [9:0] i, input logic [15:0] v);
      apb(1, i, v[7:0]);
      apb(1, i + 10'h001, v[15:8]);
   endtask
   task fall_trig;
      trig <= 1'b0;
      repeat (8) @(posedge clock);
      trig <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   function automatic logic [15:0] trig_exp(input logic en, input logic [15:0] rv, input logic [15:0] cv);
      return en ? rv : cv;
   endfunction
   function automatic logic rate_ok(input logic [15:0] v, input int clocks, input int div);
      return (int'(v) + 1 >= clocks / div) && (int'(v) <= clocks / div + 1);
   endfunction
   function automatic int baud_ticks(input int clocks, input logic [15:0] rv);
      return clocks / (2 * (65536 - int'(rv)));
   endfunction
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_sim;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, irq_en, smode} = '0;
      {trig, clr, cpin} = 3'b111;
      resetn = 1'b0;
      void'($urandom(32'hBF5E));
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      clr <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apb(0, CT + i[9:0], 8'h00);
         chk("reset value", 16'h0000, {8'h00, q});
      end
      apb(0, 10'h0C0, 8'h00);
      chk("unmapped error", 16'h0001, {15'h0000, err});
      // overflow reloads from the capture/reload pair, flag sticks
      apb(1, CK, 8'h20);
      wr16(RL, 16'h1200);
      wr16(CL, 16'hFFFE);
      apb(1, CT, 8'h04);
      repeat (30) @(posedge clock);
      apb(0, CT, 8'h00);
      chk("overflow flag", 16'h0084, {8'h00, q});
      irq_en <= 1'b1;
      apb(1, CT, 8'h80);
      chk("irq", 16'h0001, {15'h0000, irq});
      rd16(CL);
      chk("reload high", 16'h0012, {8'h00, w[15:8]});
      r = w;
      repeat (20) @(posedge clock);
      rd16(CL);
      chk("held count", r, w);
      for (int i = 0; i < 3; i++) begin
         apb(1, CT, 8'h40 << i);
         apb(0, CT, 8'h00);
         chk("flag write", {8'h00, 8'h40 << i}, {8'h00, q});
         chk("irq level", {15'h0000, i < 2}, {15'h0000, irq});
      end
      // random reload by trigger, enabled and ignored
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         c = $urandom;
         wr16(RL, r);
         wr16(CL, c);
         apb(1, CT, {4'h0, i[0], 3'h0});
         fall_trig;
         rd16(CL);
         chk("trigger reload", trig_exp(i[0], r, c), w);
         apb(0, CT, 8'h00);
         chk("external flag", {8'h00, 1'b0, i[0], 2'b00, i[0], 3'h0}, {8'h00, q});
         apb(1, CT, 8'h00);
      end
      // capture with and without auto clear
      for (int i = 0; i < 2; i++) begin
         c = $urandom;
         apb(1, MD, {4'h0, i[0], 3'h0});
         wr16(CL, c);
         apb(1, CT, 8'h09);
         fall_trig;
         rd16(RL);
         chk("capture", c, w);
         rd16(CL);
         chk("auto clear", i[0] ? 16'h0000 : c, w);
      end
      apb(1, MD, 8'h00);
      // counter mode on count pin edges
      wr16(CL, 16'h0000);
      apb(1, CT, 8'h06);
      repeat (5) begin
         cpin <= 1'b1;
         repeat (3) @(posedge clock);
         cpin <= 1'b0;
         repeat (3) @(posedge clock);
      end
      repeat (5) @(posedge clock);
      apb(1, CT, 8'h00);
      rd16(CL);
      chk("pin count", 16'h0005, w);
      // slow then fast prescale; the run lasts 99 clock edges
      for (int i = 0; i < 2; i++) begin
         apb(1, CK, {2'b00, i[0], 5'h00});
         wr16(CL, 16'h0000);
         apb(1, CT, 8'h04);
         repeat (96) @(posedge clock);
         apb(1, CT, 8'h00);
         rd16(CL);
         chk("tick rate", 16'h0001, {15'h0000, rate_ok(w, 98, i[0] ? int'(tcrb_pkg::DIV_FAST) :
            int'(tcrb_pkg::DIV_SLOW))});
      end
      // down count reaches reload value
      apb(1, MD, 8'h01);
      wr16(RL, 16'h0100);
      wr16(CL, 16'h0103);
      trig <= 1'b0;
      apb(1, CT, 8'h04);
      repeat (30) @(posedge clock);
      apb(1, CT, 8'h80);
      rd16(CL);
      chk("down wrap", 16'h00FF, {8'h00, w[15:8]});
      trig <= 1'b1;
      wr16(CL, 16'h0100);
      apb(1, CT, 8'h04);
      repeat (30) @(posedge clock);
      apb(1, CT, 8'h00);
      rd16(CL);
      chk("up count", 16'h0001, {15'h0000, w > 16'h0100 && w < 16'h0110});
      apb(1, MD, 8'h00);
      // baud generation, both selects and transmit only
      for (int i = 0; i < 3; i++) begin
         smode <= {1'b0, i != 2};
         wr16(RL, 16'hFFF0);
         wr16(CL, 16'hFFF0);
         apb(1, CT, i == 1 ? 8'h14 : 8'h34);
         clr <= 1'b1;
         @(posedge clock);
         clr <= 1'b0;
         repeat (320) @(posedge clock);
         chk("baud rate", 16'h0001, {15'h0000, ovc + 1 >= baud_ticks(320, 16'hFFF0)
            && ovc <= baud_ticks(320, 16'hFFF0)});
         chk("tx tick", i == 2 ? 16'h0000 : {8'h00, ovc}, {8'h00, txc});
         chk("rx tick", i == 2 ? 16'h0000 : {8'h00, i == 1 ? t1c : ovc}, {8'h00, rxc});
         apb(0, CT, 8'h00);
         chk("no baud flag", {8'h00, 2'b00, i != 1, 5'h14}, {8'h00, q & 8'hF4});
         apb(1, CT, 8'h00);
      end
      end_sim;
   end
endmodule
`default_nettype wire

// ### verif/tcrb_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcrb_serial_model (
   // clock
   input wire logic clock,
   input wire logic clear,
   // timer side
   input wire logic rx_baud_tick,
   input wire logic tx_baud_tick,
   input wire logic overflow_pulse,
   output logic timer1_overflow,
   // tallies
   output logic [7:0] rx_count,
   output logic [7:0] tx_count,
   output logic [7:0] ovf_count,
   output logic [7:0] t1_count
);
   logic [2:0] div_reg;
   wire t1_hit = (div_reg == 3'h6);
   // timer 1 overflow every 7 clocks
   always_ff @(posedge clock) begin
      div_reg <= (t1_hit || clear) ? 3'h0 : div_reg + 3'h1;
      timer1_overflow <= t1_hit && !clear;
   end
   // receive and transmit time bases tallied apart
   always_ff @(posedge clock) begin
      rx_count <= clear ? 8'h00 : rx_count + {7'h00, rx_baud_tick};
      tx_count <= clear ? 8'h00 : tx_count + {7'h00, tx_baud_tick};
      ovf_count <= clear ? 8'h00 : ovf_count + {7'h00, overflow_pulse};
      t1_count <= clear ? 8'h00 : t1_count + {7'h00, timer1_overflow};
   end
endmodule
`default_nettype wire
